// >>> verilog/cmps_params.svh
// Constants for the control-mode pin select block and its host end
//
// Function
// - Floating mode pin selects extended control mode
// - Pin-strapped mode: serial port off, pins rule
// - Swing pin low reduced, high normal swing
// - Edge pin low negative, high positive edge
// - Floating edge pin selects double data rate
// - Delay pin low short, high long; driven
// - Extended mode: pins become clock, data, select
// - Host writes all eight registers before use
// - First interleave write loads the default value
// - Non-default interleave settings only after full initial write
`ifndef CMPS_PARAMS_SVH
`define CMPS_PARAMS_SVH

// Pin slots on the link
`define CMPS_NPINS         4
`define CMPS_PIN_SWING     0
`define CMPS_PIN_EDGE      1
`define CMPS_PIN_CAL       2
`define CMPS_PIN_MODE      3

// Serial frame: 4 address bits then 16 data bits, MSB first
`define CMPS_ADDR_W        4
`define CMPS_DATA_W        16
`define CMPS_FRAME_BITS    20
`define CMPS_CNT_W         5
`define CMPS_NREGS         8
`define CMPS_SLOT_W        3

// Device register map
`define CMPS_ILV_ADDR      4'hd
`define CMPS_ILV_SLOT      3'h6
`define CMPS_ILV_RESET     16'h3fff
`define CMPS_REG_RESET     16'h0000

// Host register offsets
`define CMPS_HOST_CTRL     4'h0
`define CMPS_HOST_SADDR    4'h1
`define CMPS_HOST_SERIAL_BIT_INPUT    4'h2
`define CMPS_HOST_GO       4'h3
`define CMPS_HOST_STATUS   4'h4

// Host control fields and reset value
`define CMPS_CTRL_EXT      0
`define CMPS_CTRL_RANGE    1
`define CMPS_CTRL_SWING    2
`define CMPS_CTRL_EDGE_LO  3
`define CMPS_CTRL_EDGE_HI  4
`define CMPS_CTRL_CAL      5
`define CMPS_CTRL_RESET    16'h000e
`define CMPS_EDGE_NEG      2'h0
`define CMPS_EDGE_POS      2'h1
`define CMPS_EDGE_DDR      2'h2

// Host status fields
`define CMPS_STAT_BUSY     0
`define CMPS_STAT_INIT     1
`define CMPS_STAT_REFUSED  2
`define CMPS_STAT_MASK_LO  8

// Serial clock timing
`define CMPS_REF_PERIOD_NS 100
`define CMPS_SCLK_HALF_NS  200
`define CMPS_SCLK_HALF_CYC \
   ((`CMPS_SCLK_HALF_NS + `CMPS_REF_PERIOD_NS - 1) / `CMPS_REF_PERIOD_NS)

`endif

// >>> verilog/cmps_pkg.sv
// Types and shared decoding for the control-mode pin select block
`include "cmps_params.svh"

package cmps_pkg;

   typedef logic [`CMPS_ADDR_W-1:0] cmps_addr_t;
   typedef logic [`CMPS_DATA_W-1:0] cmps_data_t;
   typedef logic [`CMPS_SLOT_W-1:0] cmps_slot_t;

   typedef enum logic [2:0] {
      HST_IDLE,
      HST_LEAD,
      HST_LOW,
      HST_HIGH,
      HST_TAIL
   } cmps_hst_e;

   // Bit 3 flags a user register, bits 2:0 give its slot
   function automatic logic [3:0] cmps_slot_of(input cmps_addr_t addr);
      case (addr)
         4'h1:    cmps_slot_of = 4'h8;
         4'h2:    cmps_slot_of = 4'h9;
         4'h3:    cmps_slot_of = 4'ha;
         4'h9:    cmps_slot_of = 4'hb;
         4'ha:    cmps_slot_of = 4'hc;
         4'hb:    cmps_slot_of = 4'hd;
         4'hd:    cmps_slot_of = 4'he;
         4'he:    cmps_slot_of = 4'hf;
         default: cmps_slot_of = 4'h0;
      endcase
   endfunction : cmps_slot_of

endpackage : cmps_pkg

// >>> verilog/cmps_link_if.sv
// Strap and serial pins between host and device
`timescale 1ns/100ps
`include "cmps_params.svh"

interface cmps_link_if;
   logic [`CMPS_NPINS-1:0] pin_level;
   logic [`CMPS_NPINS-1:0] pin_oe;

   modport host (
      output pin_level,
      output pin_oe
   );

   modport device (
      input  pin_level,
      input  pin_oe
   );
endinterface : cmps_link_if

// >>> verilog/cmps_frame_rx.sv
// Serial frame receiver on the link clock
`timescale 1ns/100ps
`include "cmps_params.svh"

module cmps_frame_rx
   import cmps_pkg::*;
(
   // Clock and reset
   input  logic               link_clk,
   input  logic               reset_n,
   // Sampled serial pins
   input  logic               sel_act,
   input  logic               sclk_rise,
   input  logic               sbit,
   // Frame out
   output logic               frame_vld,
   output cmps_pkg::cmps_addr_t frame_addr,
   output cmps_pkg::cmps_data_t frame_data
);
   import cmps_pkg::*;

   logic [`CMPS_FRAME_BITS-1:0] shift_r;
   logic [`CMPS_CNT_W-1:0]      cnt_r;
   logic                        vld_r;
   logic                        last_bit;

   assign last_bit = (cnt_r == `CMPS_CNT_W'(`CMPS_FRAME_BITS - 1));

   // Deselect drops a part frame, so a glitchy host never half-writes
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= '0;
      end else if (!sel_act) begin
         cnt_r <= '0;
      end else if (sclk_rise &&
                   cnt_r != `CMPS_CNT_W'(`CMPS_FRAME_BITS)) begin
         cnt_r <= cnt_r + `CMPS_CNT_W'(1);
      end
   end

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         shift_r <= '0;
      end else if (sel_act && sclk_rise &&
                   cnt_r != `CMPS_CNT_W'(`CMPS_FRAME_BITS)) begin
         shift_r <= {shift_r[`CMPS_FRAME_BITS-2:0], sbit};
      end
   end

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         vld_r <= 1'b0;
      end else begin
         vld_r <= sel_act && sclk_rise && last_bit;
      end
   end

   assign frame_vld  = vld_r;
   assign frame_addr = shift_r[`CMPS_FRAME_BITS-1:`CMPS_DATA_W];
   assign frame_data = shift_r[`CMPS_DATA_W-1:0];

endmodule : cmps_frame_rx

// >>> verilog/cmps_device.sv
// Device end: strap decode, serial register port, user registers
//
// Chosen here: the serial clock, data and select port.
`timescale 1ns/100ps
`include "cmps_params.svh"

module cmps_device
   import cmps_pkg::*;
(
   // Link clock and reset
   input  logic                   link_clk,
   input  logic                   reset_n,
   // Pins
   cmps_link_if.device            link,
   // Decoded mode
   output logic                   ext_mode,
   output logic                   serial_active,
   output logic                   range_normal,
   output logic                   swing_normal,
   output logic                   edge_pos,
   output logic                   ddr_mode,
   output logic                   cal_wait_long,
   // Register contents
   output cmps_pkg::cmps_data_t   interleave_enable,
   output logic [`CMPS_NREGS-1:0] written_mask,
   output logic                   all_written,
   input  cmps_pkg::cmps_slot_t   rd_slot,
   output cmps_pkg::cmps_data_t   rd_data
);
   import cmps_pkg::*;

   logic [`CMPS_NPINS-1:0] lvl_s1_r;
   logic [`CMPS_NPINS-1:0] lvl_s2_r;
   logic [`CMPS_NPINS-1:0] drv_s1_r;
   logic [`CMPS_NPINS-1:0] drv_s2_r;
   logic                   sclk_prev_r;
   logic                   ext_r;
   logic                   sel_r;
   logic                   range_r;
   logic                   swing_r;
   logic                   edge_r;
   logic                   ddr_r;
   logic                   cal_r;
   cmps_data_t             regs_r [`CMPS_NREGS];
   logic [`CMPS_NREGS-1:0] written_r;
   cmps_data_t             rd_data_r;
   cmps_slot_t             slot_s1_r, slot_s2_r;
   logic                   ext_now;
   logic                   sel_now;
   logic                   sclk_now;
   logic                   sclk_rise;
   logic                   frame_vld;
   cmps_addr_t             frame_addr;
   cmps_data_t             frame_data;
   logic [3:0]             frame_slot;

   // Pins come from another clock: two flops before any use
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         lvl_s1_r <= 4'hb;
         lvl_s2_r <= 4'hb;
      end else begin
         lvl_s1_r <= link.pin_level;
         lvl_s2_r <= lvl_s1_r;
      end
   end

   // Output enable stands in for the float sense of a real pad
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         drv_s1_r <= '1;
         drv_s2_r <= '1;
      end else begin
         drv_s1_r <= link.pin_oe;
         drv_s2_r <= drv_s1_r;
      end
   end

   assign ext_now = !drv_s2_r[`CMPS_PIN_MODE];

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         ext_r <= 1'b0;
      end else begin
         ext_r <= ext_now;
      end
   end

   // Range follows the mode pin only while it is driven
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         range_r <= 1'b1;
      end else if (!ext_now) begin
         range_r <= lvl_s2_r[`CMPS_PIN_MODE];
      end
   end

   // Strapped settings hold their last value in extended mode
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         swing_r <= 1'b1;
      end else if (!ext_now) begin
         swing_r <= lvl_s2_r[`CMPS_PIN_SWING];
      end
   end

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         edge_r <= 1'b1;
         ddr_r  <= 1'b0;
      end else if (!ext_now) begin
         if (drv_s2_r[`CMPS_PIN_EDGE]) begin
            edge_r <= lvl_s2_r[`CMPS_PIN_EDGE];
            ddr_r  <= 1'b0;
         end else begin
            ddr_r  <= 1'b1;
         end
      end
   end

   // Delay pin must be driven; a floating pin keeps the old setting
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         cal_r <= 1'b0;
      end else if (!ext_now && drv_s2_r[`CMPS_PIN_CAL]) begin
         cal_r <= lvl_s2_r[`CMPS_PIN_CAL];
      end
   end

   // Pins turn into the serial port only in extended mode
   assign sclk_now = ext_now && lvl_s2_r[`CMPS_PIN_SWING];
   assign sel_now  = ext_now && drv_s2_r[`CMPS_PIN_CAL] &&
                     !lvl_s2_r[`CMPS_PIN_CAL];

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         sclk_prev_r <= 1'b0;
      end else begin
         sclk_prev_r <= sclk_now;
      end
   end

   assign sclk_rise = sclk_now && !sclk_prev_r && sel_now;

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         sel_r <= 1'b0;
      end else begin
         sel_r <= sel_now;
      end
   end

   cmps_frame_rx u_rx (
      .link_clk   (link_clk),
      .reset_n    (reset_n),
      .sel_act    (sel_now),
      .sclk_rise  (sclk_rise),
      .sbit       (lvl_s2_r[`CMPS_PIN_EDGE]),
      .frame_vld  (frame_vld),
      .frame_addr (frame_addr),
      .frame_data (frame_data)
   );

   assign frame_slot = cmps_slot_of(frame_addr);

   // One register per slot; unknown addresses are dropped
   for (genvar i = 0; i < `CMPS_NREGS; i++) begin : g_reg
      localparam cmps_data_t RST = (i == `CMPS_ILV_SLOT) ?
                                   `CMPS_ILV_RESET : `CMPS_REG_RESET;
      always_ff @(posedge link_clk or negedge reset_n) begin
         if (!reset_n) begin
            regs_r[i] <= RST;
         end else if (frame_vld && frame_slot[3] &&
                      frame_slot[2:0] == `CMPS_SLOT_W'(i)) begin
            regs_r[i] <= frame_data;
         end
      end

      always_ff @(posedge link_clk or negedge reset_n) begin
         if (!reset_n) begin
            written_r[i] <= 1'b0;
         end else if (frame_vld && frame_slot[3] &&
                      frame_slot[2:0] == `CMPS_SLOT_W'(i)) begin
            written_r[i] <= 1'b1;
         end
      end
   end

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data_r <= '0;
         slot_s1_r <= '0;
         slot_s2_r <= '0;
      end else begin
         slot_s1_r <= rd_slot;
         slot_s2_r <= slot_s1_r;
         rd_data_r <= regs_r[slot_s2_r];
      end
   end

   assign ext_mode          = ext_r;
   assign serial_active     = sel_r;
   assign range_normal      = range_r;
   assign swing_normal      = swing_r;
   assign edge_pos          = edge_r;
   assign ddr_mode          = ddr_r;
   assign cal_wait_long     = cal_r;
   assign interleave_enable = regs_r[`CMPS_ILV_SLOT];
   assign written_mask      = written_r;
   assign all_written       = &written_r;
   assign rd_data           = rd_data_r;

endmodule : cmps_device

// >>> verilog/cmps_host.sv
// Host end: strap drive and serial register writer
`timescale 1ns/100ps
`include "cmps_params.svh"

module cmps_host
   import cmps_pkg::*;
(
   // Clock and reset
   input  logic                 ref_clk,
   input  logic                 reset_n,
   // Software port
   input  cmps_pkg::cmps_addr_t sw_addr,
   input  cmps_pkg::cmps_data_t sw_wdata,
   input  logic                 sw_wr,
   input  logic                 sw_rd,
   output cmps_pkg::cmps_data_t sw_rdata,
   // Pins
   cmps_link_if.host            link,
   // Status
   output logic                 converter_ready
);
   import cmps_pkg::*;

   cmps_data_t             ctrl_r;
   cmps_addr_t             saddr_r;
   cmps_data_t             serial_bit_input_reg_r;
   logic [`CMPS_NREGS-1:0] sent_r;
   logic                   refused_r;
   cmps_data_t             rdata_r;
   cmps_hst_e              st_r;
   logic [3:0]             cnt_r;
   logic [`CMPS_CNT_W-1:0] bitn_r;
   logic [`CMPS_FRAME_BITS-1:0] shreg_r;
   logic                   sclk_r;
   logic                   sbit_r;
   logic                   scs_n_r;
   logic [`CMPS_NPINS-1:0] lvl_r;
   logic [`CMPS_NPINS-1:0] oe_r;
   logic                   busy;
   logic                   go;
   logic [3:0]             slot;
   logic                   is_ilv;
   logic                   init_done;
   logic                   refuse;
   logic                   start;
   logic                   half_done;
   logic [1:0]             edge_md;
   cmps_data_t             send_data;

   assign busy      = (st_r != HST_IDLE);
   assign init_done = &sent_r;
   assign go        = sw_wr && sw_addr == `CMPS_HOST_GO &&
                      !busy && ctrl_r[`CMPS_CTRL_EXT];
   assign slot      = cmps_slot_of(saddr_r);
   assign is_ilv    = (saddr_r == `CMPS_ILV_ADDR);
   // First interleave frame always carries the default
   assign send_data = (is_ilv && !sent_r[`CMPS_ILV_SLOT]) ?
                      `CMPS_ILV_RESET : serial_bit_input_reg_r;
   assign refuse    = go && is_ilv && sent_r[`CMPS_ILV_SLOT] &&
                      !init_done && serial_bit_input_reg_r != `CMPS_ILV_RESET;
   assign start     = go && !refuse;
   assign half_done = (cnt_r == 4'(`CMPS_SCLK_HALF_CYC - 1));
   assign edge_md   = ctrl_r[`CMPS_CTRL_EDGE_HI:`CMPS_CTRL_EDGE_LO];

   // Mode changes mid-frame would corrupt it, so control writes while busy are dropped
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r <= `CMPS_CTRL_RESET;
      end else if (sw_wr && sw_addr == `CMPS_HOST_CTRL && !busy) begin
         ctrl_r <= sw_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         saddr_r     <= '0;
         serial_bit_input_reg_r <= '0;
      end else if (sw_wr && sw_addr == `CMPS_HOST_SADDR) begin
         saddr_r <= sw_wdata[`CMPS_ADDR_W-1:0];
      end else if (sw_wr && sw_addr == `CMPS_HOST_SERIAL_BIT_INPUT) begin
         serial_bit_input_reg_r <= sw_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sent_r <= '0;
      end else if (start && slot[3]) begin
         sent_r[slot[2:0]] <= 1'b1;
      end
   end

   // A refusal in the clearing cycle still sticks
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         refused_r <= 1'b0;
      end else if (refuse) begin
         refused_r <= 1'b1;
      end else if (sw_wr && sw_addr == `CMPS_HOST_STATUS &&
                   sw_wdata[`CMPS_STAT_REFUSED]) begin
         refused_r <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_r <= '0;
      end else if (sw_rd) begin
         case (sw_addr)
            `CMPS_HOST_CTRL:   rdata_r <= ctrl_r;
            `CMPS_HOST_SADDR:  rdata_r <= {12'h000, saddr_r};
            `CMPS_HOST_SERIAL_BIT_INPUT:  rdata_r <= serial_bit_input_reg_r;
            `CMPS_HOST_STATUS: rdata_r <= {sent_r, 5'h00, refused_r,
                                           init_done, busy};
            default:           rdata_r <= '0;
         endcase
      end
   end

   // Serial clock from a divider of ref_clk; device samples on rise
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r    <= HST_IDLE;
         cnt_r   <= '0;
         bitn_r  <= '0;
         shreg_r <= '0;
         sclk_r  <= 1'b0;
         sbit_r  <= 1'b0;
         scs_n_r <= 1'b1;
      end else begin
         cnt_r <= (st_r == HST_IDLE || half_done) ? 4'h0 : cnt_r + 4'h1;
         case (st_r)
            HST_IDLE: if (start) begin
               shreg_r <= {saddr_r, send_data};
               bitn_r  <= '0;
               scs_n_r <= 1'b0;
               st_r    <= HST_LEAD;
            end
            HST_LEAD: if (half_done) begin
               sbit_r <= shreg_r[`CMPS_FRAME_BITS-1];
               st_r   <= HST_LOW;
            end
            HST_LOW: if (half_done) begin
               sclk_r <= 1'b1;
               st_r   <= HST_HIGH;
            end
            HST_HIGH: if (half_done) begin
               sclk_r  <= 1'b0;
               shreg_r <= {shreg_r[`CMPS_FRAME_BITS-2:0], 1'b0};
               if (bitn_r == `CMPS_CNT_W'(`CMPS_FRAME_BITS - 1)) begin
                  st_r <= HST_TAIL;
               end else begin
                  bitn_r <= bitn_r + `CMPS_CNT_W'(1);
                  sbit_r <= shreg_r[`CMPS_FRAME_BITS-2];
                  st_r   <= HST_LOW;
               end
            end
            HST_TAIL: if (half_done) begin
               scs_n_r <= 1'b1;
               st_r    <= HST_IDLE;
            end
            default: st_r <= HST_IDLE;
         endcase
      end
   end

   // Pin drive; the delay pin is never left floating
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         lvl_r <= 4'hb;
         oe_r  <= 4'hf;
      end else if (ctrl_r[`CMPS_CTRL_EXT]) begin
         lvl_r <= {1'b0, scs_n_r, sbit_r, sclk_r};
         oe_r  <= 4'h7;
      end else begin
         lvl_r <= {ctrl_r[`CMPS_CTRL_RANGE], ctrl_r[`CMPS_CTRL_CAL],
                   edge_md == `CMPS_EDGE_POS,
                   ctrl_r[`CMPS_CTRL_SWING]};
         oe_r  <= {1'b1, 1'b1, edge_md != `CMPS_EDGE_DDR,
                   1'b1};
      end
   end

   assign link.pin_level  = lvl_r;
   assign link.pin_oe     = oe_r;
   assign sw_rdata        = rdata_r;
   assign converter_ready = !ctrl_r[`CMPS_CTRL_EXT] || init_done;

endmodule : cmps_host

// >>> bench/cmps_link_checker.sv
// Assertions on the link pins and the decoded device state
`timescale 1ns/100ps
`include "cmps_params.svh"

module cmps_link_checker (
   // Link clock and reset
   input logic                   link_clk,
   input logic                   reset_n,
   // Pins
   input logic [`CMPS_NPINS-1:0] pin_level,
   input logic [`CMPS_NPINS-1:0] pin_oe,
   // Device state
   input logic                   ext_mode,
   input logic                   serial_active,
   input logic                   range_normal,
   input logic                   swing_normal,
   input logic                   edge_pos,
   input logic                   ddr_mode,
   input logic                   cal_wait_long,
   input cmps_pkg::cmps_data_t   interleave_enable,
   input logic [`CMPS_NREGS-1:0] written_mask
);
   import cmps_pkg::*;
   default clocking cb @(posedge link_clk); endclocking
   default disable iff (!reset_n);

   // Six stable cycles cover the two sync flops and the decode register
   a_mode_float: assert property ($fell(pin_oe[3]) |-> ##[1:6] ext_mode)
      else $error("extended mode not entered");
   a_range_strap: assert property ((pin_oe[3] && $stable(pin_oe[3])
      && $stable(pin_level[3]))[*6] |-> range_normal == pin_level[3])
      else $error("range does not follow mode pin");
   a_serial_off: assert property ((pin_oe[3] && $stable(pin_oe[3]))[*6]
      |-> !serial_active && !ext_mode)
      else $error("serial port active in strapped mode");
   a_swing_strap: assert property ((pin_oe[3] && $stable(pin_oe[3])
      && $stable(pin_level[0]))[*6] |-> swing_normal == pin_level[0])
      else $error("swing does not follow pin");
   a_edge_strap: assert property ((pin_oe[3] && pin_oe[1]
      && $stable(pin_oe[3:1]) && $stable(pin_level[1]))[*6]
      |-> edge_pos == pin_level[1] && !ddr_mode)
      else $error("edge does not follow pin");
   a_ddr_float: assert property ((pin_oe[3] && !pin_oe[1]
      && $stable(pin_oe[3:1]))[*6] |-> ddr_mode && $stable(edge_pos))
      else $error("floating edge pin without double rate");
   a_cal_strap: assert property ((pin_oe[3] && pin_oe[2]
      && $stable(pin_oe[3:2]) && $stable(pin_level[2]))[*6]
      |-> cal_wait_long == pin_level[2])
      else $error("delay does not follow pin");
   a_strap_driven: assert property (pin_oe[3] |-> pin_oe[2] && pin_oe[0])
      else $error("strap pin left floating");
   a_ext_serial: assert property ((!pin_oe[3] && pin_oe[2] && !pin_level[2]
      && $stable(pin_oe[3]) && $stable(pin_level[2]))[*6]
      |-> serial_active && ext_mode)
      else $error("serial port not active in extended mode");
   a_sel_idle: assert property ((!pin_oe[3] && pin_level[2])[*8]
      |=> $stable(interleave_enable) && $stable(written_mask))
      else $error("register changed while deselected");
   a_strap_nowr: assert property ((pin_oe[3])[*8]
      |=> $stable(interleave_enable) && $stable(written_mask))
      else $error("register changed in strapped mode");

   c_ext: cover property ($rose(ext_mode));
   c_ddr: cover property ($rose(ddr_mode));
   c_all: cover property ((&written_mask) && $changed(interleave_enable));
endmodule : cmps_link_checker

// >>> bench/test_control_mode_pin_select.sv
// Testbench joining host and device ends over the link
`timescale 1ns/100ps
`include "cmps_params.svh"

module test_control_mode_pin_select;
   import cmps_pkg::*;
   logic                   ref_clk;
   logic                   link_clk;
   logic                   reset_n;
   cmps_addr_t             sw_addr;
   cmps_data_t             sw_wdata;
   logic                   sw_wr;
   logic                   sw_rd;
   cmps_data_t             sw_rdata;
   logic                   converter_ready;
   logic                   ext_mode;
   logic                   serial_active;
   logic                   range_normal;
   logic                   swing_normal;
   logic                   edge_pos;
   logic                   ddr_mode;
   logic                   cal_wait_long;
   cmps_data_t             interleave_enable;
   logic [`CMPS_NREGS-1:0] written_mask;
   logic                   all_written;
   cmps_slot_t             rd_slot;
   cmps_data_t             rd_data;
   int                     err_total;
   int                     samples_checked;

   cmps_link_if u_cmps_link_if ();
   cmps_host u_cmps_host (.ref_clk(ref_clk), .reset_n(reset_n),
      .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
      .sw_rdata(sw_rdata), .link(u_cmps_link_if),
      .converter_ready(converter_ready));
   cmps_device u_cmps_device (.link_clk(link_clk), .reset_n(reset_n),
      .link(u_cmps_link_if), .ext_mode(ext_mode),
      .serial_active(serial_active), .range_normal(range_normal),
      .swing_normal(swing_normal), .edge_pos(edge_pos), .ddr_mode(ddr_mode),
      .cal_wait_long(cal_wait_long), .interleave_enable(interleave_enable),
      .written_mask(written_mask), .all_written(all_written),
      .rd_slot(rd_slot), .rd_data(rd_data));
   cmps_link_checker u_cmps_link_checker (.link_clk(link_clk),
      .reset_n(reset_n), .pin_level(u_cmps_link_if.pin_level),
      .pin_oe(u_cmps_link_if.pin_oe), .ext_mode(ext_mode),
      .serial_active(serial_active), .range_normal(range_normal),
      .swing_normal(swing_normal), .edge_pos(edge_pos), .ddr_mode(ddr_mode),
      .cal_wait_long(cal_wait_long), .interleave_enable(interleave_enable),
      .written_mask(written_mask));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // Odd start offset keeps the link clock out of phase with ref_clk
   initial begin
      link_clk = 1'b0;
      #3.7;
      forever #6 link_clk = ~link_clk;
   end

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic sw_write(input cmps_addr_t a, input cmps_data_t d);
      @(posedge ref_clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge ref_clk);
      sw_wr <= 1'b0;
   endtask : sw_write

   task automatic sw_read(input cmps_addr_t a, output cmps_data_t d);
      @(posedge ref_clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge ref_clk);
      sw_rd <= 1'b0;
      #1;
      d = sw_rdata;
   endtask : sw_read

   // Polls busy with a bound so a stuck frame shows as a mismatch
   task automatic send_frame(input cmps_addr_t a, input cmps_data_t d);
      cmps_data_t st;
      sw_write(`CMPS_HOST_SADDR, {12'h000, a});
      sw_write(`CMPS_HOST_SERIAL_BIT_INPUT, d);
      sw_write(`CMPS_HOST_GO, 16'h0000);
      repeat (2) @(posedge ref_clk);
      for (int n = 0; n < 200; n++) begin
         sw_read(`CMPS_HOST_STATUS, st);
         if (st[`CMPS_STAT_BUSY] === 1'b0) break;
      end
      check("busy", st[`CMPS_STAT_BUSY], 1'b0);
      repeat (4) @(posedge ref_clk);
   endtask : send_frame

   task automatic t_reset;
      cmps_data_t d;
      repeat (4) @(posedge ref_clk);
      sw_read(`CMPS_HOST_CTRL, d);
      check("ctrl", d, `CMPS_CTRL_RESET);
      sw_read(4'hf, d);
      check("unmapped", d, 16'h0000);
      check("ilv", interleave_enable, `CMPS_ILV_RESET);
      check("mask", written_mask, 8'h00);
      check("ready", converter_ready, 1'b1);
   endtask : t_reset

   task automatic t_strap;
      logic [15:0] tbl [4] = '{16'h002e, 16'h0000, 16'h0012, 16'h0004};
      logic        pos;
      pos = 1'b1;
      foreach (tbl[i]) begin
         sw_write(`CMPS_HOST_CTRL, tbl[i]);
         repeat (3) @(posedge ref_clk);
         if (tbl[i][4:3] != `CMPS_EDGE_DDR) pos = tbl[i][3];
         check("range", range_normal, tbl[i][1]);
         check("swing", swing_normal, tbl[i][2]);
         check("edge", edge_pos, pos);
         check("ddr", ddr_mode, tbl[i][4]);
         check("cal", cal_wait_long, tbl[i][5]);
         check("ext", ext_mode, 1'b0);
      end
   endtask : t_strap

   task automatic t_ext;
      logic [3:0] adr [8] = '{4'h1, 4'h2, 4'h3, 4'h9, 4'ha, 4'hb, 4'hd, 4'he};
      cmps_data_t d;
      sw_write(`CMPS_HOST_CTRL, 16'h0001);
      repeat (3) @(posedge ref_clk);
      check("ext", ext_mode, 1'b1);
      check("ready", converter_ready, 1'b0);
      send_frame(4'hd, 16'h1234);
      check("ilv", interleave_enable, `CMPS_ILV_RESET);
      check("mask", written_mask, 8'h40);
      send_frame(4'hd, 16'h0001);
      sw_read(`CMPS_HOST_STATUS, d);
      check("refused", d[`CMPS_STAT_REFUSED], 1'b1);
      check("ilv", interleave_enable, `CMPS_ILV_RESET);
      for (int i = 0; i < 8; i++)
         if (i != 6) send_frame(adr[i], 16'h5a00 + i[15:0]);
      check("mask", written_mask, 8'hff);
      check("all", all_written, 1'b1);
      check("ready", converter_ready, 1'b1);
      for (int i = 0; i < 8; i++) begin
         rd_slot <= i[2:0];
         repeat (2) @(posedge ref_clk);
         check("rd", rd_data, i == 6 ? `CMPS_ILV_RESET : 16'h5a00 + i[15:0]);
      end
      sw_write(`CMPS_HOST_STATUS, 16'h0004);
      sw_read(`CMPS_HOST_STATUS, d);
      check("cleared", d[`CMPS_STAT_REFUSED], 1'b0);
      send_frame(4'hd, 16'h0001);
      check("ilv", interleave_enable, 16'h0001);
   endtask : t_ext

   // Back in strapped mode a GO must not reach the registers
   task automatic t_back;
      sw_write(`CMPS_HOST_CTRL, 16'h0000);
      repeat (3) @(posedge ref_clk);
      check("ext", ext_mode, 1'b0);
      send_frame(4'hd, 16'h00ff);
      check("ilv", interleave_enable, 16'h0001);
   endtask : t_back

   task automatic report_and_stop;
      if (err_total == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop

   initial begin
      #1000000;
      err_total++;
      report_and_stop();
   end

   initial begin
      err_total = 0;
      samples_checked = 0;
      reset_n = 1'b0;
      sw_addr = 4'h0;
      sw_wdata = 16'h0000;
      sw_wr = 1'b0;
      sw_rd = 1'b0;
      rd_slot = 3'h0;
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'b1;
      t_reset();
      t_strap();
      t_ext();
      t_back();
      report_and_stop();
   end
endmodule : test_control_mode_pin_select
